//--- dv/crystal_model.sv
// Watch crystal model: 384-cycle square wave, held low while halted or absent
`timescale 1ns/1ps
module crystal_model (
  // Clock and controls
  input  wire aclk,
  input  wire osc_enable,
  input  wire present,
  // Crystal pin
  output reg  crystal_out = 1'b0
);
  reg [7:0] cnt_reg = 8'h00;
  // Toggle every 192 cycles while running, stand still low otherwise
  always @(posedge aclk) begin
    cnt_reg <= (cnt_reg == 8'hBF) ? 8'h00 : cnt_reg + 8'h01;
    if (!osc_enable || !present)
      crystal_out <= 1'b0;
    else if (cnt_reg == 8'hBF)
      crystal_out <= ~crystal_out;
  end
endmodule

//--- dv/pll_core_clock_control_assertions.sv
// Port checker for the PLL clock control block
`timescale 1ns/1ps
module pll_core_clock_control_assertions (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Read data
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  // Pins and status
  input wire        crystal_clk_in,
  input wire        core_in_isr,
  input wire        power_down,
  input wire        core_clk_en,
  input wire        modulator_clk_en,
  input wire        osc_enable,
  input wire        pll_locked,
  input wire        latched_ext_access_pin
);
  reg       xd_reg;
  reg       seen_reg;
  reg [9:0] gap_reg;
  // Cycles since last crystal rise, and whether lock was ever seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      xd_reg   <= 1'b0;
      seen_reg <= 1'b0;
      gap_reg  <= 10'h000;
    end else begin
      xd_reg   <= crystal_clk_in;
      seen_reg <= seen_reg | pll_locked;
      if (crystal_clk_in && !xd_reg)
        gap_reg <= 10'h000;
      else if (gap_reg != 10'h3FF)
        gap_reg <= gap_reg + 10'h001;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mod_spacing: assert property (modulator_clk_en |=> !modulator_clk_en [*8])
    else $error("modulator pulses too close");
  a_reset_div_eight: assert property (core_clk_en && !seen_reg && !core_in_isr |=> !core_clk_en [*7])
    else $error("default core period not eight");
  a_osc_halt_cause: assert property (!osc_enable |-> $past(power_down))
    else $error("oscillator off outside power-down");
  a_lock_on_edge: assert property ($rose(pll_locked) |-> gap_reg < 10'h020)
    else $error("lock without crystal edge");
  a_lock_drop: assert property (gap_reg > 10'h31F |-> !pll_locked)
    else $error("lock held without crystal");
  a_halt_core: assert property (seen_reg && !pll_locked && !$past(pll_locked) |-> !core_clk_en)
    else $error("core clock runs after lock loss");
  a_pin_frozen: assert property (seen_reg && $past(seen_reg) |-> $stable(latched_ext_access_pin))
    else $error("latched pin changed after lock");
  a_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[5])
    else $error("reserved read bits not zero");
  c_lock: cover property ($rose(pll_locked));
  c_loss: cover property (seen_reg && $fell(pll_locked));
  c_isr: cover property (core_in_isr && core_clk_en);
endmodule
bind pll_core_clock_control pll_core_clock_control_assertions chk (.*);

//--- dv/tb_pll_core_clock_control.sv
// Self-checking bench for the PLL clock control block
`timescale 1ns/1ps
`include "pll_clk_map.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_pll_core_clock_control;
  // Stimulus
  reg        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, external_access_pin = 1'b0, core_in_isr = 1'b0;
  reg        power_down = 1'b0, present = 1'b1;
  reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg [31:0] s_axi_wdata = 32'h00000000, d;
  reg [3:0]  s_axi_wstrb = 4'hF;
  reg [1:0]  r;
  // Design outputs
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, crystal_clk_in;
  wire        core_clk_en, modulator_clk_en, osc_enable, pll_locked, latched_ext_access_pin;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int         err_count = 0, check_count = 0, n, i;
  always #4 aclk = ~aclk;
  pll_core_clock_control dut (.*);
  crystal_model xtal (.aclk(aclk), .osc_enable(osc_enable), .present(present), .crystal_out(crystal_clk_in));
  // Bus write: address and data offered together, each released when taken
  task automatic wr(input [11:0] a, input [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Bus read
  task automatic rd(input [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Skip to a core pulse, then count cycles to the next one
  task automatic per(input int e);
    n = 0;
    do begin @(negedge aclk); n++; end while (core_clk_en !== 1'b1 && n < 3000);
    n = 0;
    do begin @(negedge aclk); n++; end while (core_clk_en !== 1'b1 && n < 300);
    `CHK(n, e)
  endtask
  task automatic t_lock;
    rd(`PCC_ADDR);
    `CHK(d, {24'h000000, `PCC_RESET})
    per(8);
    @(posedge aclk) external_access_pin <= 1'b1;
    n = 0;
    while (pll_locked !== 1'b1 && n < 5000) begin @(negedge aclk); n++; end
    `CHK(pll_locked, 1'b1)
    @(posedge aclk) external_access_pin <= 1'b0;
    rd(`PCC_ADDR);
    `CHK(d, 32'h00000053)
    $display("lock test done");
  endtask
  task automatic t_div;
    for (i = 0; i < 8; i++) begin
      wr(`PCC_ADDR, 8'h50 | i[7:0]);
      per(1 << i);
      rd(`PCC_ADDR);
      `CHK(d, {24'h000000, 8'h50 | i[7:0]})
    end
    $display("divider test done");
  endtask
  task automatic t_fast;
    wr(`PCC_ADDR, 8'h07);
    @(posedge aclk) core_in_isr <= 1'b1;
    per(128);
    wr(`PCC_ADDR, 8'h0F);
    per(1);
    @(posedge aclk) core_in_isr <= 1'b0;
    repeat (2) @(posedge aclk);
    per(128);
    wr(12'h000, 8'h80);
    `CHK(r, `RESP_SLVERR)
    rd(12'h000);
    `CHK({d, r}, {32'h00000000, `RESP_SLVERR})
    rd(`PCC_ADDR);
    `CHK(d, 32'h0000005F)
    $display("fast and bus test done");
  endtask
  task automatic t_loss;
    @(posedge aclk) power_down <= 1'b1;
    repeat (4) @(negedge aclk);
    `CHK(osc_enable, 1'b1)
    wr(`PCC_ADDR, 8'h83);
    repeat (4) @(negedge aclk);
    `CHK(osc_enable, 1'b0)
    @(posedge aclk) begin power_down <= 1'b0; present <= 1'b0; end
    repeat (1000) @(negedge aclk);
    `CHK(pll_locked, 1'b0)
    rd(`PCC_ADDR);
    `CHK(d, 32'h00000093)
    n = 0;
    repeat (200) begin @(negedge aclk); if (core_clk_en !== 1'b0) n++; end
    `CHK(n, 0)
    $display("power-down and loss test done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_lock;
    t_div;
    t_fast;
    t_loss;
    tally_and_finish;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    tally_and_finish;
  end
endmodule

//--- rtl/pin_sync.v
// Three-stage synchroniser for an input that arrives from outside the clock domain
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Raw pin and filtered level
  input  wire pin_in,
  output reg  level_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // Shift chain; level changes once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule

//--- rtl/pll_clk_map.vh
// Register map, field positions and timing constants for the PLL clock control block
`ifndef PLL_CLK_MAP_VH
`define PLL_CLK_MAP_VH
// Register index and byte address (index counts 32-bit words, so byte address is four times it)
`define PCC_IDX            8'hD7
`define PCC_ADDR           10'h35C
`define PCC_RESET          8'h03
// Field positions
`define PCC_OSC_HALT_BIT   7
`define PCC_LOCK_BIT       6
`define PCC_RSVD_BIT       5
`define PCC_LATCHED_EXT_ACCESS_PIN_BIT       4
`define PCC_FAST_ISR_SPEED_BIT       3
`define PCC_DIV_MSB        2
`define PCC_DIV_LSB        0
// Write mask: only bits 7, 3 and 2..0 are software writable
`define PCC_WR_MASK        8'h8F
// PLL multiplication factor and modulator divide
`define PLL_MULT           9'h180
`define PLL_MULT_LAST      9'h17F
// Lock: edges seen in tolerance before lock, PLL cycles without a crystal edge before loss
`define LOCK_GOOD_COUNT    4'h4
`define LOCK_SLACK         9'h020
`define LOSS_TIMEOUT       10'h300
// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

//--- rtl/pll_core_clock_control.v
// PLL clock control: core clock enable, modulator enable, lock status and control register
//
// Notes on behaviour
// - PLL clock is 384 times crystal; modelled by aclk, checked by crystal edge spacing.
// - Reset selects divide by 8 (divider field 3) for the core.
// - Modulator enable pulses once per 384 PLL cycles from a free-running counter, not tied to crystal edges or lock.
// - Divider field n divides the PLL clock by two to the power n.
// - Bit 7 set halts the oscillator in power-down; clear keeps it running.
// - Read-only bit 6 reads one while the PLL tracks the crystal.
// - Lock bit clears whenever tracking fails; PLL then runs free.
// - Crystal lost after lock stops the core clock until lock returns.
// - Read-only bit 4 shows external access pin, followed after reset release and latched when the PLL first locks.
// - Fast interrupt bit set runs interrupt service at the fastest core clock.
// - On interrupt return, the core clock returns to the divider setting.
`timescale 1ns/1ps
`include "pll_clk_map.vh"
module pll_core_clock_control (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Crystal, pins and core status
  input  wire        crystal_clk_in,
  input  wire        external_access_pin,
  input  wire        core_in_isr,
  input  wire        power_down,
  // Clock outputs and status
  output reg         core_clk_en,
  output reg         modulator_clk_en,
  output reg         osc_enable,
  output reg         pll_locked,
  output reg         latched_ext_access_pin
);

  // Synchronised crystal and access pin
  wire xtal_lvl;
  wire ea_lvl;
  reg  xtal_prev_reg;
  wire xtal_rise;

  pin_sync u_xtal_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (crystal_clk_in),
    .level_out (xtal_lvl)
  );

  pin_sync u_ea_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (external_access_pin),
    .level_out (ea_lvl)
  );

  assign xtal_rise = xtal_lvl & ~xtal_prev_reg;

  // Control register fields
  reg        osc_halt_in_sleep_reg;
  reg        fast_isr_speed_reg;
  reg  [2:0] core_div_reg;
  reg        ea_captured_reg;

  // Lock tracker state and modulator counter
  reg  [9:0] edge_gap_reg;
  reg  [3:0] good_cnt_reg;
  reg  [8:0] mod_cnt_reg;

  // Core divider state
  reg  [6:0] div_cnt_reg;
  reg  [2:0] active_div_reg;
  wire [2:0] wanted_div;
  wire [6:0] period_last;
  wire [7:0] reset_value;

  // Reset byte of the control register; divider field is its low bits
  assign reset_value = `PCC_RESET;

  // Bus handshake state
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg  [3:0] wstrb_reg;
  wire       wr_fire;
  wire       wr_hit;
  wire [7:0] status_byte;

  // Crystal edge spacing checks lock; missing edges mean loss
  always @(posedge aclk) begin
    if (!aresetn) begin
      xtal_prev_reg <= 1'b0;
      edge_gap_reg  <= 10'h000;
      good_cnt_reg  <= 4'h0;
      pll_locked    <= 1'b0;
    end else begin
      xtal_prev_reg <= xtal_lvl;
      if (xtal_rise) begin
        edge_gap_reg <= 10'h000;
        if ((edge_gap_reg[8:0] + `LOCK_SLACK >= `PLL_MULT_LAST) &&
            (edge_gap_reg <= {1'b0, `PLL_MULT_LAST} + {1'b0, `LOCK_SLACK})) begin
          if (good_cnt_reg == `LOCK_GOOD_COUNT) begin
            pll_locked <= 1'b1;
          end else begin
            good_cnt_reg <= good_cnt_reg + 4'h1;
          end
        end else begin
          good_cnt_reg <= 4'h0;
          pll_locked   <= 1'b0;
        end
      end else if (edge_gap_reg == `LOSS_TIMEOUT) begin
        good_cnt_reg <= 4'h0;
        pll_locked   <= 1'b0;
      end else begin
        edge_gap_reg <= edge_gap_reg + 10'h001;
      end
    end
  end

  // Modulator enable: one pulse per crystal period, counted on the PLL clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      mod_cnt_reg      <= 9'h000;
      modulator_clk_en <= 1'b0;
    end else begin
      if (mod_cnt_reg == `PLL_MULT_LAST) begin
        mod_cnt_reg      <= 9'h000;
        modulator_clk_en <= 1'b1;
      end else begin
        mod_cnt_reg      <= mod_cnt_reg + 9'h001;
        modulator_clk_en <= 1'b0;
      end
    end
  end

  // Divider wanted now: fastest during fast interrupt service
  assign wanted_div  = (fast_isr_speed_reg && core_in_isr) ? 3'h0 : core_div_reg;
  assign period_last = (7'h01 << active_div_reg) - 7'h01;

  // Core clock enable; divider swaps only at end of a period
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg    <= 7'h00;
      active_div_reg <= reset_value[`PCC_DIV_MSB:`PCC_DIV_LSB];
      core_clk_en    <= 1'b0;
    end else begin
      if (div_cnt_reg >= period_last) begin
        div_cnt_reg    <= 7'h00;
        active_div_reg <= wanted_div;
        core_clk_en    <= ~ea_captured_reg | pll_locked;
      end else begin
        div_cnt_reg <= div_cnt_reg + 7'h01;
        core_clk_en <= 1'b0;
      end
    end
  end

  // Oscillator runs unless halted in power-down
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_enable <= 1'b1;
    end else begin
      osc_enable <= ~(power_down & osc_halt_in_sleep_reg);
    end
  end

  // Access pin followed until first lock, then held; marks ever-locked for loss detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      latched_ext_access_pin <= 1'b0;
      ea_captured_reg        <= 1'b0;
    end else begin
      if (!ea_captured_reg) begin
        latched_ext_access_pin <= ea_lvl;
      end
      if (pll_locked) begin
        ea_captured_reg <= 1'b1;
      end
    end
  end

  // Read view of the control register
  assign status_byte = {osc_halt_in_sleep_reg, pll_locked, 1'b0, latched_ext_access_pin,
                        fast_isr_speed_reg, core_div_reg};

  // Write channel: take address and data in either order
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_hit  = (awaddr_reg[11:2] == `PCC_ADDR >> 2);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 12'h000;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      osc_halt_in_sleep_reg <= 1'b0;
      fast_isr_speed_reg    <= 1'b0;
      core_div_reg          <= reset_value[`PCC_DIV_MSB:`PCC_DIV_LSB];
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_hit) begin
          s_axi_bresp <= `RESP_OKAY;
          if (wstrb_reg[0]) begin
            osc_halt_in_sleep_reg <= wdata_reg[`PCC_OSC_HALT_BIT];
            fast_isr_speed_reg    <= wdata_reg[`PCC_FAST_ISR_SPEED_BIT];
            core_div_reg          <= wdata_reg[`PCC_DIV_MSB:`PCC_DIV_LSB];
          end
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answer the cycle after acceptance
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr[11:2] == `PCC_ADDR >> 2) begin
          s_axi_rdata <= {24'h000000, status_byte};
          s_axi_rresp <= `RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
